// >>> atc_consts.vh
`ifndef ATC_CONSTS_VH
`define ATC_CONSTS_VH
// ----------------------------------------
// Trigger source codes
// ----------------------------------------
`define ATC_SRC_NONE 2'h0
`define ATC_SRC_DIG 2'h1
`define ATC_SRC_ANA 2'h2
`define ATC_SRC_STAR 2'h3
// ----------------------------------------
// Trigger type codes
// ----------------------------------------
`define ATC_TYPE_PRE 2'h0
`define ATC_TYPE_MID 2'h1
`define ATC_TYPE_POST 2'h2
`define ATC_TYPE_DELAY 2'h3
`define ATC_TYPE_RESET 2'h2
// ----------------------------------------
// Analog conditions
// ----------------------------------------
`define ATC_COND_ABOVE 2'h0
`define ATC_COND_BELOW 2'h1
`define ATC_COND_WINDOW 2'h2
// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define ATC_MAX_POINTS 24'h800000
`define ATC_POINTS_W 24
`define ATC_DELAY_W 32
`define ATC_ADC_W 16
`define ATC_TB_INT_MHZ 48
`define ATC_TB_EXT_MIN_MHZ 1
`define ATC_TB_EXT_MAX_MHZ 48
`endif

// >>> atc_far_side.sv
`timescale 1ns/10ps
// ----
// Trigger pins and first-channel feed
// ----
module atc_far_side (
  input wire sys_clk,
  output reg in_pin,
  output reg out_pin,
  output reg ana_pin,
  output reg tbase_pin,
  output reg [15:0] chan,
  output reg chan_ok,
  output reg star_pin
);
  initial begin
    {in_pin, out_pin, ana_pin, tbase_pin, chan_ok, star_pin} = 6'h00;
    chan = 16'h0000;
  end
  // The external timebase runs free, well below the top rate.
  always @(posedge sys_clk) begin
    tbase_pin <= ~tbase_pin;
  end
  task drive_pin(input int sel, input bit lvl);
    @(posedge sys_clk);
    case (sel)
      0: in_pin <= lvl;
      1: out_pin <= lvl;
      2: ana_pin <= lvl;
      default: star_pin <= lvl;
    endcase
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task send_sample(input logic [15:0] v);
    @(posedge sys_clk);
    chan <= v;
    chan_ok <= 1'b1;
    @(posedge sys_clk);
    // Stale data is inverted so a missing qualifier cannot hide.
    chan <= ~v;
    chan_ok <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
endmodule // atc_far_side

// >>> atc_trigger.v
`timescale 1ns/10ps
`include "atc_consts.vh"

// One path (input or output) of the trigger controller.
module atc_path (
  input wire sys_clk,
  input wire reset,
  input wire start,
  input wire abort,
  input wire continuous,
  input wire [1:0] src,
  input wire [1:0] ttype,
  input wire ana_from_chan,
  input wire [`ATC_POINTS_W-1:0] points,
  input wire [`ATC_DELAY_W-1:0] delay_count,
  input wire dig_edge,
  input wire ana_hit,
  input wire star_edge,
  input wire tb_tick,
  input wire sample_tick,
  output reg convert,
  output reg busy,
  output reg done,
  output reg cfg_error,
  output reg triggered
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_DELAY = 3'h2;
  localparam ST_POST = 3'h3;
  localparam ST_DONE = 3'h4;

  reg [2:0] state;
  reg [`ATC_DELAY_W-1:0] delay_left;
  reg [`ATC_POINTS_W-1:0] left;
  reg [`ATC_POINTS_W-1:0] pre_taken;
  reg imm_pend;
  reg [1:0] eff_type;
  reg bad;
  reg fire;
  wire [`ATC_POINTS_W-1:0] req_pts;
  wire [`ATC_POINTS_W-1:0] half_pts;

  assign req_pts = (points > `ATC_MAX_POINTS) ? `ATC_MAX_POINTS : points;
  assign half_pts = {1'b0, req_pts[`ATC_POINTS_W-1:1]};

  always @* begin
    eff_type = ttype;
    bad = 1'b0;
    if (continuous && ttype != `ATC_TYPE_POST) begin
      bad = 1'b1;
    end
    if ((ttype == `ATC_TYPE_PRE || ttype == `ATC_TYPE_MID) &&
        (src == `ATC_SRC_NONE ||
         (src == `ATC_SRC_ANA && ana_from_chan))) begin
      bad = 1'b1;
    end
  end

  always @* begin
    case (src)
      `ATC_SRC_NONE: fire = imm_pend;
      `ATC_SRC_DIG: fire = dig_edge;
      `ATC_SRC_ANA: fire = ana_hit;
      `ATC_SRC_STAR: fire = star_edge;
      default: fire = 1'b0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      delay_left <= {`ATC_DELAY_W{1'b0}};
      left <= {`ATC_POINTS_W{1'b0}};
      pre_taken <= {`ATC_POINTS_W{1'b0}};
      imm_pend <= 1'b0;
      convert <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      cfg_error <= 1'b0;
      triggered <= 1'b0;
    end else begin
      convert <= 1'b0;
      imm_pend <= 1'b0;
      if (abort) begin
        state <= ST_IDLE;
        busy <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start) begin
              cfg_error <= bad;
              done <= 1'b0;
              triggered <= 1'b0;
              if (!bad) begin
                imm_pend <= 1'b1;
                busy <= 1'b1;
                left <= req_pts;
                pre_taken <= {`ATC_POINTS_W{1'b0}};
                state <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            if (sample_tick && (eff_type == `ATC_TYPE_PRE ||
                                eff_type == `ATC_TYPE_MID)) begin
              convert <= 1'b1;
              if (pre_taken != req_pts) begin
                pre_taken <= pre_taken + 1'b1;
              end
            end
            if (fire) begin
              triggered <= 1'b1;
              case (eff_type)
                `ATC_TYPE_PRE: state <= ST_DONE;
                `ATC_TYPE_MID: begin
                  left <= half_pts;
                  state <= ST_POST;
                end
                `ATC_TYPE_DELAY: begin
                  delay_left <= delay_count;
                  state <= ST_DELAY;
                end
                default: state <= ST_POST;
              endcase
            end
          end
          ST_DELAY: begin
            if (delay_left == {`ATC_DELAY_W{1'b0}}) begin
              state <= ST_POST;
            end else if (tb_tick) begin
              delay_left <= delay_left - 1'b1;
            end
          end
          ST_POST: begin
            if (left == {`ATC_POINTS_W{1'b0}} && !continuous) begin
              state <= ST_DONE;
            end else if (sample_tick) begin
              convert <= 1'b1;
              if (!continuous) begin
                left <= left - 1'b1;
              end
            end
          end
          ST_DONE: begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // atc_path

// Top: two paths sharing one analog detector.
module atc_trigger (
  input wire sys_clk,
  input wire reset,
  input wire input_path_digital_trigger_pin,
  input wire output_path_digital_trigger_pin,
  input wire star_trigger_pin,
  input wire external_timebase_pin,
  input wire use_external_timebase,
  input wire external_analog_trigger_pin,
  input wire [`ATC_ADC_W-1:0] first_chan_sample,
  input wire first_chan_valid,
  input wire [`ATC_ADC_W-1:0] high_threshold,
  input wire [`ATC_ADC_W-1:0] low_threshold,
  input wire [1:0] analog_condition,
  input wire first_scan_channel_source,
  input wire ai_start,
  input wire ai_abort,
  input wire ai_continuous,
  input wire [1:0] ai_source,
  input wire [1:0] ai_type,
  input wire ai_polarity_negative,
  input wire ai_dig_from_output_pin,
  input wire [`ATC_POINTS_W-1:0] ai_points,
  input wire [`ATC_DELAY_W-1:0] ai_delay_count,
  input wire ai_sample_tick,
  input wire ao_start,
  input wire ao_abort,
  input wire ao_continuous,
  input wire [1:0] ao_source,
  input wire [1:0] ao_type,
  input wire ao_polarity_negative,
  input wire ao_dig_from_output_pin,
  input wire [`ATC_POINTS_W-1:0] ao_points,
  input wire [`ATC_DELAY_W-1:0] ao_delay_count,
  input wire ao_sample_tick,
  output wire ai_convert,
  output wire ai_busy,
  output wire ai_done,
  output wire ai_config_error,
  output wire ai_triggered,
  output wire ao_convert,
  output wire ao_busy,
  output wire ao_done,
  output wire ao_config_error,
  output wire ao_triggered
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two-stage synchronise
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg [4:0] sync_c;
  wire [4:0] pins_raw;
  assign pins_raw = {external_analog_trigger_pin, external_timebase_pin,
                     star_trigger_pin, output_path_digital_trigger_pin,
                     input_path_digital_trigger_pin};
  always @(posedge sys_clk) begin
    if (reset) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_c <= 5'h00;
    end else begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  wire [4:0] rise;
  wire [4:0] fall;
  assign rise = sync_b & ~sync_c;
  assign fall = ~sync_b & sync_c;

  wire ai_dig_lvl_r;
  wire ai_dig_lvl_f;
  wire ao_dig_lvl_r;
  wire ao_dig_lvl_f;
  assign ai_dig_lvl_r = ai_dig_from_output_pin ? rise[1] : rise[0];
  assign ai_dig_lvl_f = ai_dig_from_output_pin ? fall[1] : fall[0];
  assign ao_dig_lvl_r = ao_dig_from_output_pin ? rise[1] : rise[0];
  assign ao_dig_lvl_f = ao_dig_from_output_pin ? fall[1] : fall[0];
  wire ai_dig_edge;
  wire ao_dig_edge;
  assign ai_dig_edge = ai_polarity_negative ? ai_dig_lvl_f : ai_dig_lvl_r;
  assign ao_dig_edge = ao_polarity_negative ? ao_dig_lvl_f : ao_dig_lvl_r;

  // ----------------------------------------
  // Shared analog detector
  // ----------------------------------------
  // The external comparator pin already carries the threshold decision;
  // the first-channel sample is compared here against the same settings.
  // Condition select
  reg chan_hit;
  always @* begin
    case (analog_condition)
      `ATC_COND_ABOVE: chan_hit = first_chan_sample > high_threshold;
      `ATC_COND_BELOW: chan_hit = first_chan_sample < low_threshold;
      `ATC_COND_WINDOW: chan_hit = first_chan_sample > low_threshold &&
                                   first_chan_sample < high_threshold;
      default: chan_hit = 1'b0;
    endcase
  end
  reg ana_hit;
  always @(posedge sys_clk) begin
    if (reset) begin
      ana_hit <= 1'b0;
    end else if (first_scan_channel_source) begin
      ana_hit <= chan_hit && first_chan_valid && (ai_busy || ao_busy);
    end else begin
      ana_hit <= rise[4];
    end
  end

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  // External timebase tick
  wire tb_tick;
  assign tb_tick = use_external_timebase ? rise[3] : 1'b1;

  atc_path u_ai (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(ai_start),
    .abort(ai_abort),
    .continuous(ai_continuous),
    .src(ai_source),
    .ttype(ai_type),
    .ana_from_chan(first_scan_channel_source),
    .points(ai_points),
    .delay_count(ai_delay_count),
    .dig_edge(ai_dig_edge),
    .ana_hit(ana_hit),
    .star_edge(rise[2]),
    .tb_tick(tb_tick),
    .sample_tick(ai_sample_tick),
    .convert(ai_convert),
    .busy(ai_busy),
    .done(ai_done),
    .cfg_error(ai_config_error),
    .triggered(ai_triggered)
  );

  atc_path u_ao (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(ao_start),
    .abort(ao_abort),
    .continuous(ao_continuous),
    .src(ao_source),
    .ttype(ao_type),
    .ana_from_chan(first_scan_channel_source),
    .points(ao_points),
    .delay_count(ao_delay_count),
    .dig_edge(ao_dig_edge),
    .ana_hit(ana_hit),
    .star_edge(rise[2]),
    .tb_tick(tb_tick),
    .sample_tick(ao_sample_tick),
    .convert(ao_convert),
    .busy(ao_busy),
    .done(ao_done),
    .cfg_error(ao_config_error),
    .triggered(ao_triggered)
  );
endmodule // atc_trigger

// >>> atc_trigger_sva.sv
`timescale 1ns/10ps
// ----
// Trigger controller checks
// ----
module atc_trigger_sva (
  input wire sys_clk,
  input wire reset,
  input wire ai_start,
  input wire ai_abort,
  input wire ai_continuous,
  input wire [1:0] ai_source,
  input wire [1:0] ai_type,
  input wire ai_sample_tick,
  input wire ai_convert,
  input wire ai_busy,
  input wire ai_done,
  input wire ai_config_error,
  input wire ai_triggered,
  input wire ao_start,
  input wire ao_abort,
  input wire ao_continuous,
  input wire [1:0] ao_type,
  input wire ao_busy,
  input wire ao_config_error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // A start is taken only while the path is idle.
  sequence s_take;
    ai_start && !ai_busy && !ai_abort;
  endsequence
  sequence s_imm_post;
    s_take ##0 (ai_source == 2'h0 && ai_type == 2'h2 && !ai_continuous);
  endsequence
  a_imm_fires: assert property (
    s_imm_post ##1 !ai_abort |-> ai_busy ##1 ai_triggered)
    else $error("immediate trigger late");
  a_cont_refused: assert property (
    s_take ##0 (ai_continuous && ai_type != 2'h2)
    |=> ai_config_error && !ai_busy) else $error("continuous start taken");
  a_imm_pre_refused: assert property (
    s_take ##0 (ai_source == 2'h0 && !ai_type[1])
    |=> ai_config_error && !ai_busy) else $error("immediate pre taken");
  a_post_taken: assert property (
    s_take ##0 (ai_type == 2'h2) |=> ai_busy && !ai_config_error)
    else $error("post start refused");
  a_ao_refused: assert property (
    ao_start && !ao_busy && !ao_abort && ao_continuous && ao_type != 2'h2
    |=> ao_config_error) else $error("output path start taken");
  a_convert_paced: assert property (
    ai_convert |-> $past(ai_sample_tick)) else $error("convert unpaced");
  a_trig_holds: assert property (
    ai_triggered && !ai_start && !ai_abort |=> ai_triggered)
    else $error("trigger lost");
  a_done_ends: assert property (
    $rose(ai_done) |-> !ai_busy && $past(ai_busy))
    else $error("done without busy end");
endmodule // atc_trigger_sva
bind atc_trigger atc_trigger_sva i_atc_trigger_sva (.sys_clk, .reset,
  .ai_start, .ai_abort, .ai_continuous, .ai_source, .ai_type,
  .ai_sample_tick, .ai_convert, .ai_busy, .ai_done, .ai_config_error,
  .ai_triggered, .ao_start, .ao_abort, .ao_continuous, .ao_type, .ao_busy,
  .ao_config_error);

// >>> atc_trigger_tb.sv
`timescale 1ns/10ps
`include "atc_consts.vh"
// ----
// Trigger controller bench
// ----
module atc_trigger_tb;
  reg sys_clk, reset, ext, fsc, cont, pol, opin, tick, ai_st, ao_st, ab;
  reg [1:0] src, typ, cond;
  reg [15:0] hi, lo;
  reg [23:0] pts;
  reg [31:0] dly;
  wire in_p, out_p, ana_p, tb_p, ch_ok, ai_cv, ai_bz, ai_dn, ai_er, ai_tg;
  wire ao_cv, ao_bz, ao_dn, ao_er, ao_tg, star_p;
  wire [15:0] ch;
  int bad_count, num_checks, n, k, i;
  logic e;
  logic [15:0] miss [3] = '{16'h6000, 16'h6000, 16'h9000};
  logic [15:0] hit [3] = '{16'h9000, 16'h3000, 16'h6000};
  atc_far_side i_atc_far_side (.sys_clk(sys_clk), .in_pin(in_p),
    .out_pin(out_p), .ana_pin(ana_p), .tbase_pin(tb_p), .chan(ch),
    .chan_ok(ch_ok), .star_pin(star_p));
  atc_trigger i_atc_trigger (.sys_clk(sys_clk), .reset(reset),
    .input_path_digital_trigger_pin(in_p),
    .output_path_digital_trigger_pin(out_p), .star_trigger_pin(star_p),
    .external_timebase_pin(tb_p), .use_external_timebase(ext),
    .external_analog_trigger_pin(ana_p), .first_chan_sample(ch),
    .first_chan_valid(ch_ok), .high_threshold(hi), .low_threshold(lo),
    .analog_condition(cond), .first_scan_channel_source(fsc),
    .ai_start(ai_st), .ai_abort(ab), .ai_continuous(cont), .ai_source(src),
    .ai_type(typ), .ai_polarity_negative(pol), .ai_dig_from_output_pin(opin),
    .ai_points(pts), .ai_delay_count(dly), .ai_sample_tick(tick),
    .ao_start(ao_st), .ao_abort(ab), .ao_continuous(cont), .ao_source(src),
    .ao_type(typ), .ao_polarity_negative(pol), .ao_dig_from_output_pin(opin),
    .ao_points(pts), .ao_delay_count(dly), .ao_sample_tick(tick),
    .ai_convert(ai_cv), .ai_busy(ai_bz), .ai_done(ai_dn),
    .ai_config_error(ai_er), .ai_triggered(ai_tg), .ao_convert(ao_cv),
    .ao_busy(ao_bz), .ao_done(ao_dn), .ao_config_error(ao_er),
    .ao_triggered(ao_tg));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task arm(input bit both);
    @(posedge sys_clk);
    ai_st <= 1'b1;
    ao_st <= both;
    @(posedge sys_clk);
    ai_st <= 1'b0;
    ao_st <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task stop;
    @(posedge sys_clk);
    ab <= 1'b1;
    @(posedge sys_clk);
    ab <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Pace samples until the input path reports done, counting conversions.
  task drain;
    k = 0;
    for (n = 0; n < 60 && ai_dn !== 1'b1; n++) begin
      @(posedge sys_clk);
      tick <= (n % 3 == 0);
      #1 k += (ai_cv === 1'b1) + (ao_cv === 1'b1);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // A healthy run needs under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    {reset, ext, fsc, cont, pol, opin, tick, ai_st, ao_st, ab} = 10'h200;
    {src, typ, cond} = 6'h08;
    hi = 16'h8000;
    lo = 16'h4000;
    pts = 24'h000002;
    dly = 32'h0000000a;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 64; i++) begin
      {fsc, cont, typ, src} <= i[5:0];
      e = i[4] ? (i[3:2] != 2) :
          (i[3:2] < 2 && (i[1:0] == 0 || (i[1:0] == 2 && i[5])));
      arm(1);
      chk({ai_er, ai_bz, ao_er, ao_bz}, {e, !e, e, !e});
      stop;
    end
    $display("start table end");
    {fsc, cont, typ, src} <= {2'h0, `ATC_TYPE_POST, `ATC_SRC_NONE};
    arm(1);
    drain;
    chk(k, 4);
    chk({ai_tg, ai_bz, ai_dn, ao_dn, ao_bz}, 5'b10110);
    $display("post run end");
    @(posedge sys_clk);
    {tick, src, pol, opin} <= {1'b0, `ATC_SRC_DIG, 2'b11};
    arm(1);
    i_atc_far_side.drive_pin(0, 1);
    i_atc_far_side.drive_pin(0, 0);
    i_atc_far_side.drive_pin(1, 1);
    chk({ai_tg, ao_tg}, 2'b00);
    i_atc_far_side.drive_pin(1, 0);
    chk({ai_tg, ao_tg}, 2'b11);
    stop;
    $display("digital end");
    {tick, src, typ} <= {1'b1, `ATC_SRC_NONE, `ATC_TYPE_DELAY};
    for (i = 0; i < 2; i++) begin
      ext <= i[0];
      arm(0);
      for (n = 0; n < 200 && ai_cv !== 1'b1; n++) @(posedge sys_clk) #1;
      chk(n >= (i + 1) * 10, 1);
      chk(n <= (i + 1) * 10 + 16, 1);
      stop;
    end
    $display("delay end");
    {ext, tick, fsc, src, typ} <= {3'h1, `ATC_SRC_ANA, `ATC_TYPE_POST};
    for (i = 0; i < 3; i++) begin
      cond <= i[1:0];
      arm(1);
      i_atc_far_side.send_sample(miss[i]);
      chk({ai_tg, ao_tg}, 2'b00);
      i_atc_far_side.send_sample(hit[i]);
      chk({ai_tg, ao_tg}, 2'b11);
      stop;
    end
    fsc <= 1'b0;
    arm(1);
    i_atc_far_side.drive_pin(2, 1);
    chk({ai_tg, ao_tg}, 2'b11);
    i_atc_far_side.drive_pin(2, 0);
    stop;
    src <= `ATC_SRC_STAR;
    arm(1);
    chk({ai_tg, ao_tg}, 2'b00);
    i_atc_far_side.drive_pin(3, 1);
    chk({ai_tg, ao_tg}, 2'b11);
    i_atc_far_side.drive_pin(3, 0);
    stop;
    $display("analog end");
    for (i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      {tick, src, typ, pol, opin} <= {1'b1, `ATC_SRC_DIG, i[1:0], 2'b00};
      pts <= 24'h000004;
      arm(0);
      chk(ai_cv, 1);
      @(posedge sys_clk);
      tick <= 1'b0;
      i_atc_far_side.drive_pin(0, 1);
      chk({ai_tg, ai_dn}, {1'b1, i == 0});
      drain;
      chk(k, i * 2);
      chk({ai_dn, ai_bz}, 2'b10);
      i_atc_far_side.drive_pin(0, 0);
    end
    $display("trigger type end");
    final_report;
  end
endmodule // atc_trigger_tb
